// ### hw/dpt_panel.sv
// panel test functions: fault view, jog, forced outputs, io diagnosis
// What this block does
// - with a fault record selected, set shows that record's stored code
// - set on jog speed parameter shows jog speed, twenty r/min after reset
// - up/down change jog speed; shift moves blinking digit that up/down change
// - set while editing accepts speed, enters jog mode, shows jog indication
// - in jog, up held turns ccw, down held turns cw, else no rotation
// - mode in jog shows jog parameter name; next set shows speed for edit
// - jog motion only while the drive is servo-on
// - writing 406 to output control mode enables forced outputs
// - each force value bit drives one output, bit 0 to output 1
// - force value is cleared at power-up; outputs return to normal
// - writing 400 to output control mode returns outputs to normal
// - forced outputs act only while servo-off
// - normal outputs 1 to 5 follow their function settings, output 6 the last function signal
// - input status shows inputs 1 to 9 as hex bit map, 1 is on
// - output status shows outputs 1 to 6 as hex bit map, 1 is on
// - force value shown in hex with leading fifth digit zero blanked
`default_nettype none
module dpt_panel #(
  parameter int          NUM_DI  = dpt_pkg::NUM_DI,
  parameter int          NUM_DO  = dpt_pkg::NUM_DO,
  parameter logic [15:0] JOG_MAX = 16'h1388
) (
  // clock and reset
  input  wire logic                               ref_clk,
  input  wire logic                               nrst,
  // apb slave
  input  wire logic                               psel,
  input  wire logic                               penable,
  input  wire logic                               pwrite,
  input  wire logic [7:0]                         paddr,
  input  wire logic [31:0]                        pwdata,
  output logic      [31:0]                        prdata,
  output logic                                    pready,
  output logic                                    pslverr,
  // operator keypad and display
  input  wire dpt_pkg::dpt_keys_t                 keys,
  output dpt_pkg::dpt_disp_t                      disp,
  // drive state and fault history
  input  wire logic                               servoOn,
  input  wire logic [dpt_pkg::NUM_FAULT-1:0][15:0] faultCode,
  // motor command path
  output dpt_pkg::dpt_motor_t                     motorCmd,
  // digital pins
  input  wire logic [NUM_DI-1:0]                  digitalInput,
  input  wire logic [dpt_pkg::NUM_FUNC-1:0]       funcSig,
  output logic      [NUM_DO-1:0]                  digitalOutput,
  // interrupt
  output logic                                    irq
);
  import dpt_pkg::*;

  // ************************************************
  // elaboration checks
  // ************************************************
  if (NUM_DI != dpt_pkg::NUM_DI || NUM_DO != dpt_pkg::NUM_DO) begin : g_chk
    $error("dpt_panel: pin counts must match the package layout");
  end
  if (JOG_MAX < RST_JOG_SPEED) begin : g_chk_max
    $error("dpt_panel: JOG_MAX below the reset jog speed");
  end

  // ************************************************
  // state
  // ************************************************
  typedef struct packed {
    dpt_menu_t           menu;
    logic [3:0]          sel;
    logic [15:0]         jogSpeed;
    logic [2:0]          digit;
    logic [15:0]         modeParam;
    logic                forceEn;
    logic [NUM_DO-1:0]   forceVal;
    dpt_cfg_t            cfg;
    logic [NUM_IRQ-1:0]  irqStat;
    logic [NUM_IRQ-1:0]  irqMask;
    logic [NUM_DI-1:0]   inStat;
    logic [NUM_DO-1:0]   outStat;
    logic [NUM_DO-1:0]   dout;
    logic                upQ;
    logic                downQ;
    logic [31:0]         rdata;
    dpt_disp_t           disp;
    dpt_motor_t          motor;
  } dpt_state_t;

  localparam dpt_state_t ST_RESET = '{
    menu:      MENU_NAME,
    sel:       SEL_JOG,
    jogSpeed:  RST_JOG_SPEED,
    modeParam: MODE_NORMAL,
    cfg:       {NUM_CFG{RST_CFG}},
    disp:      '{mode: DSP_NAME, value: 20'h00005, default: '0},
    default:   '0
  };

  dpt_state_t st_r;
  dpt_state_t st_nxt;
  logic [NUM_DO-1:0] doutMap;

  // ************************************************
  // output mapping
  // ************************************************
  dpt_dout_map #(
    .NUM_DO   (NUM_DO)
  ) u_map (
    .funcSig  (funcSig),
    .cfg      (st_r.cfg),
    .forceEn  (st_r.forceEn),
    .servoOn  (servoOn),
    .forceVal (st_r.forceVal),
    .doutNxt  (doutMap)
  );

  // ************************************************
  // helpers
  // ************************************************
  // decimal step of the active digit
  function automatic logic [15:0] digitStep(input logic [2:0] d);
    logic [15:0] s;
    s = 16'h0001;
    unique case (d)
      3'h1:    s = 16'h000a;
      3'h2:    s = 16'h0064;
      3'h3:    s = 16'h03e8;
      3'h4:    s = 16'h2710;
      default: s = 16'h0001;
    endcase
    return s;
  endfunction : digitStep

  // blank the leading hex zero of the fifth digit
  function automatic logic [NUM_DIG-1:0] hexBlank(input logic [19:0] v);
    return {(v[19:16] == 4'h0), {(NUM_DIG-1){1'b0}}};
  endfunction : hexBlank

  // ************************************************
  // apb decode
  // ************************************************
  logic setupRd;
  logic wrAcc;
  logic cfgHit;
  logic [2:0] cfgIdx;
  logic mapped;
  assign setupRd = psel & ~penable;
  assign wrAcc   = psel & penable & pwrite;
  assign cfgIdx  = 3'((paddr - OFS_CFG_BASE) >> 2);
  // range checked on the full address so offsets above the table do not alias
  assign cfgHit  = (paddr >= OFS_CFG_BASE) && (paddr[1:0] == 2'b00)
                   && (paddr < OFS_CFG_BASE + 8'(4 * NUM_CFG));
  always_comb begin
    unique case (paddr)
      OFS_PARAM_SEL, OFS_OUT_MODE, OFS_FORCE_VAL, OFS_IN_STAT,
      OFS_OUT_STAT, OFS_JOG_SPEED, OFS_IRQ_STAT, OFS_IRQ_MASK: mapped = 1'b1;
      default: mapped = cfgHit;
    endcase
  end

  // ************************************************
  // next state
  // ************************************************
  logic upEdge;
  logic downEdge;
  logic [15:0] step;
  logic [NUM_IRQ-1:0] evt;
  logic jogAllowed;
  assign upEdge     = keys.upKey & ~st_r.upQ;
  assign downEdge   = keys.downKey & ~st_r.downQ;
  assign step       = digitStep(st_r.digit);
  assign jogAllowed = servoOn;

  always_comb begin
    st_nxt       = st_r;
    evt          = '0;
    st_nxt.upQ   = keys.upKey;
    st_nxt.downQ = keys.downKey;
    // pin maps resampled every cycle
    st_nxt.inStat  = digitalInput;
    st_nxt.outStat = st_r.dout;
    st_nxt.dout    = doutMap;

    // keypad menu
    unique case (st_r.menu)
      MENU_NAME: begin
        if (keys.setKey) begin
          st_nxt.menu  = (st_r.sel == SEL_JOG) ? MENU_EDIT : MENU_VALUE;
          st_nxt.digit = '0;
        end
      end
      MENU_VALUE: begin
        if (keys.modeKey || keys.setKey) begin
          st_nxt.menu = MENU_NAME;
        end
      end
      MENU_EDIT: begin
        if (keys.modeKey) begin
          st_nxt.menu = MENU_NAME;
        end else if (keys.setKey) begin
          st_nxt.menu = MENU_JOG;
          evt         = evt | IRQ_JOG_ENTER;
        end else if (keys.shiftKey) begin
          st_nxt.digit = (st_r.digit == 3'(NUM_DIG-1)) ? 3'h0 : st_r.digit + 3'h1;
        end else if (upEdge) begin
          st_nxt.jogSpeed = (JOG_MAX - st_r.jogSpeed < step) ? JOG_MAX
                            : st_r.jogSpeed + step;
        end else if (downEdge) begin
          st_nxt.jogSpeed = (st_r.jogSpeed < step) ? 16'h0000
                            : st_r.jogSpeed - step;
        end
      end
      MENU_JOG: begin
        if (keys.modeKey) begin
          st_nxt.menu = MENU_NAME;
          st_nxt.sel  = SEL_JOG;
        end
      end
    endcase

    // motor command: ccw on up, cw on down, both or none stops
    st_nxt.motor.speed = st_r.jogSpeed;
    st_nxt.motor.run   = (st_nxt.menu == MENU_JOG) && jogAllowed
                         && (keys.upKey ^ keys.downKey);
    st_nxt.motor.ccw   = keys.upKey;
    if (st_r.motor.run && !servoOn) begin
      evt = evt | IRQ_JOG_ABORT;
    end

    // apb writes take effect in the access phase
    if (wrAcc) begin
      unique case (paddr)
        OFS_PARAM_SEL: begin
          st_nxt.sel  = pwdata[3:0];
          st_nxt.menu = MENU_NAME;
        end
        OFS_OUT_MODE: begin
          st_nxt.modeParam = pwdata[15:0];
          if (pwdata[15:0] == MODE_FORCE) begin
            st_nxt.forceEn = 1'b1;
            evt            = evt | IRQ_FORCE_CHG;
          end else if (pwdata[15:0] == MODE_NORMAL) begin
            st_nxt.forceEn = 1'b0;
            evt            = evt | IRQ_FORCE_CHG;
          end
        end
        OFS_FORCE_VAL: st_nxt.forceVal = pwdata[NUM_DO-1:0];
        OFS_JOG_SPEED: begin
          st_nxt.jogSpeed = (pwdata[15:0] > JOG_MAX) ? JOG_MAX : pwdata[15:0];
        end
        OFS_IRQ_STAT: st_nxt.irqStat = st_r.irqStat & ~pwdata[NUM_IRQ-1:0];
        OFS_IRQ_MASK: st_nxt.irqMask = pwdata[NUM_IRQ-1:0];
        default: begin
          if (cfgHit) begin
            st_nxt.cfg[cfgIdx] = pwdata[4:0];
          end
        end
      endcase
    end
    // a new event wins over a clear in the same cycle
    st_nxt.irqStat = st_nxt.irqStat | evt;

    // read data captured in the setup phase
    st_nxt.rdata = '0;
    if (setupRd && !pwrite) begin
      unique case (paddr)
        OFS_PARAM_SEL: st_nxt.rdata = {28'h0000000, st_r.sel};
        OFS_OUT_MODE:  st_nxt.rdata = {16'h0000, st_r.modeParam};
        OFS_FORCE_VAL: st_nxt.rdata = {26'h0000000, st_r.forceVal};
        OFS_IN_STAT:   st_nxt.rdata = {23'h000000, st_r.inStat};
        OFS_OUT_STAT:  st_nxt.rdata = {26'h0000000, st_r.outStat};
        OFS_JOG_SPEED: st_nxt.rdata = {16'h0000, st_r.jogSpeed};
        OFS_IRQ_STAT:  st_nxt.rdata = {29'h00000000, st_r.irqStat};
        OFS_IRQ_MASK:  st_nxt.rdata = {29'h00000000, st_r.irqMask};
        default: begin
          if (cfgHit) begin
            st_nxt.rdata = {27'h0000000, st_r.cfg[cfgIdx]};
          end
        end
      endcase
    end

    // display content for the next menu state
    st_nxt.disp.blinkOn    = 1'b0;
    st_nxt.disp.blinkDigit = st_nxt.digit;
    st_nxt.disp.blank      = '0;
    unique case (st_nxt.menu)
      MENU_NAME: begin
        st_nxt.disp.mode  = DSP_NAME;
        st_nxt.disp.value = {16'h0000, st_nxt.sel};
      end
      MENU_EDIT: begin
        st_nxt.disp.mode    = DSP_SPEED;
        st_nxt.disp.value   = {4'h0, st_nxt.jogSpeed};
        st_nxt.disp.blinkOn = 1'b1;
      end
      MENU_JOG: begin
        st_nxt.disp.mode  = DSP_JOG;
        st_nxt.disp.value = {4'h0, st_nxt.jogSpeed};
      end
      MENU_VALUE: begin
        st_nxt.disp.mode  = DSP_HEX;
        st_nxt.disp.value = '0;
        st_nxt.disp.blank = hexBlank(20'h00000);
        if (st_nxt.sel <= SEL_FAULT_LAST) begin
          st_nxt.disp.mode  = DSP_FAULT;
          st_nxt.disp.value = {4'h0, faultCode[st_nxt.sel[2:0]]};
        end else if (st_nxt.sel == SEL_FORCE) begin
          st_nxt.disp.value = {14'h0000, st_nxt.forceVal};
          st_nxt.disp.blank = hexBlank(st_nxt.disp.value);
        end else if (st_nxt.sel == SEL_IN_STAT) begin
          st_nxt.disp.value = {11'h000, st_nxt.inStat};
          st_nxt.disp.blank = hexBlank(st_nxt.disp.value);
        end else if (st_nxt.sel == SEL_OUT_STAT) begin
          st_nxt.disp.value = {14'h0000, st_nxt.outStat};
          st_nxt.disp.blank = hexBlank(st_nxt.disp.value);
        end else if (st_nxt.sel == SEL_OUT_MODE) begin
          st_nxt.disp.mode  = DSP_DEC;
          st_nxt.disp.value = {4'h0, st_nxt.modeParam};
        end
      end
    endcase
  end

  // ************************************************
  // state register; force value cleared at power-up
  // ************************************************
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      st_r <= ST_RESET;
    end else begin
      st_r <= st_nxt;
    end
  end

  // ************************************************
  // outputs
  // ************************************************
  assign prdata        = st_r.rdata;
  assign pready        = psel & penable;
  assign pslverr       = psel & penable & ~mapped;
  assign disp          = st_r.disp;
  assign digitalOutput = st_r.dout;
  // rotation cut the same cycle servo-on drops
  assign motorCmd      = '{run:   st_r.motor.run & servoOn,
                           ccw:   st_r.motor.ccw,
                           speed: st_r.motor.speed};
  assign irq           = |(st_r.irqStat & st_r.irqMask);
endmodule : dpt_panel
`default_nettype wire

// ### hw/dpt_pkg.sv
// shared constants and carrier types of the drive panel test functions
`default_nettype none
package dpt_pkg;
  // ************************************************
  // register offsets
  // ************************************************
  localparam logic [7:0] OFS_PARAM_SEL = 8'h00;
  localparam logic [7:0] OFS_OUT_MODE  = 8'h04;
  localparam logic [7:0] OFS_FORCE_VAL = 8'h08;
  localparam logic [7:0] OFS_IN_STAT   = 8'h0c;
  localparam logic [7:0] OFS_OUT_STAT  = 8'h10;
  localparam logic [7:0] OFS_JOG_SPEED = 8'h14;
  localparam logic [7:0] OFS_IRQ_STAT  = 8'h18;
  localparam logic [7:0] OFS_IRQ_MASK  = 8'h1c;
  localparam logic [7:0] OFS_CFG_BASE  = 8'h20;
  // ************************************************
  // sizes, values after reset, codes
  // ************************************************
  localparam int NUM_DI   = 9;
  localparam int NUM_DO   = 6;
  localparam int NUM_CFG  = 5;
  localparam int NUM_FAULT = 5;
  localparam int NUM_FUNC = 16;
  localparam int NUM_DIG  = 5;
  localparam int NUM_IRQ  = 3;
  localparam logic [15:0] RST_JOG_SPEED = 16'h0014;
  localparam logic [15:0] MODE_FORCE    = 16'h0196;
  localparam logic [15:0] MODE_NORMAL   = 16'h0190;
  localparam logic [4:0]  RST_CFG       = 5'h00;
  localparam logic [2:0]  IRQ_JOG_ENTER = 3'h1;
  localparam logic [2:0]  IRQ_JOG_ABORT = 3'h2;
  localparam logic [2:0]  IRQ_FORCE_CHG = 3'h4;
  // parameter codes for the panel selection
  localparam logic [3:0] SEL_FAULT_LAST = 4'h4;
  localparam logic [3:0] SEL_JOG        = 4'h5;
  localparam logic [3:0] SEL_FORCE      = 4'h6;
  localparam logic [3:0] SEL_IN_STAT    = 4'h7;
  localparam logic [3:0] SEL_OUT_STAT   = 4'h9;
  localparam logic [3:0] SEL_OUT_MODE   = 4'ha;
  // ************************************************
  // types
  // ************************************************
  typedef enum logic [1:0] {
    MENU_NAME  = 2'b00,
    MENU_VALUE = 2'b01,
    MENU_EDIT  = 2'b10,
    MENU_JOG   = 2'b11
  } dpt_menu_t;
  typedef enum logic [2:0] {
    DSP_NAME  = 3'b000,
    DSP_FAULT = 3'b001,
    DSP_SPEED = 3'b010,
    DSP_JOG   = 3'b011,
    DSP_HEX   = 3'b100,
    DSP_DEC   = 3'b101
  } dpt_dmode_t;
  typedef struct packed {
    logic setKey;
    logic modeKey;
    logic shiftKey;
    logic upKey;
    logic downKey;
  } dpt_keys_t;
  typedef struct packed {
    dpt_dmode_t          mode;
    logic [19:0]         value;
    logic [2:0]          blinkDigit;
    logic                blinkOn;
    logic [NUM_DIG-1:0]  blank;
  } dpt_disp_t;
  typedef struct packed {
    logic        run;
    logic        ccw;
    logic [15:0] speed;
  } dpt_motor_t;
  typedef logic [NUM_CFG-1:0][4:0] dpt_cfg_t;
endpackage : dpt_pkg
`default_nettype wire

// ### hw/dpt_dout_map.sv
// digital output mapper: normal function routing or forced test values
`default_nettype none
module dpt_dout_map #(
  parameter int NUM_DO = dpt_pkg::NUM_DO
) (
  // function sources and configuration
  input  wire logic [dpt_pkg::NUM_FUNC-1:0] funcSig,
  input  wire dpt_pkg::dpt_cfg_t            cfg,
  // force control
  input  wire logic                         forceEn,
  input  wire logic                         servoOn,
  input  wire logic [NUM_DO-1:0]            forceVal,
  // mapped output levels
  output logic      [NUM_DO-1:0]            doutNxt
);
  import dpt_pkg::*;

  // ************************************************
  // per output routing
  // ************************************************
  logic useForce;
  assign useForce = forceEn & ~servoOn;

  for (genvar i = 0; i < NUM_DO; i++) begin : g_out
    logic normalLvl;
    if (i < NUM_CFG) begin : g_cfg
      // function select in low bits, top bit inverts the sense
      assign normalLvl = funcSig[cfg[i][3:0]] ^ cfg[i][4];
    end else begin : g_fix
      assign normalLvl = funcSig[NUM_FUNC-1];
    end
    // bit 0 of the force value drives output 1
    assign doutNxt[i] = useForce ? forceVal[i] : normalLvl;
  end
endmodule : dpt_dout_map
`default_nettype wire

// ### sim/dpt_operator.sv
// operator model: keypad presses and fault history of the drive
`default_nettype none
module dpt_operator (
  // clock
  input  wire logic                           ref_clk,
  // keypad and fault records
  output dpt_pkg::dpt_keys_t                  keys,
  output logic [dpt_pkg::NUM_FAULT-1:0][15:0] faultCode
);
  timeunit 1ns;
  timeprecision 1ns;
  import dpt_pkg::*;
  logic upHold = 1'b0;
  logic dnHold = 1'b0;
  // fixed history, one distinct code per record
  for (genvar i = 0; i < NUM_FAULT; i++) begin : g_fault
    assign faultCode[i] = 16'h0e10 + 16'(i);
  end
  initial keys = '0;
  // one-cycle press laid over the held arrow levels
  task automatic press(input dpt_keys_t k);
    @(posedge ref_clk);
    keys <= k | {3'h0, upHold, dnHold};
    @(posedge ref_clk);
    keys <= {3'h0, upHold, dnHold};
  endtask : press
  // arrow keys held as levels for jogging
  task automatic hold(input logic u, input logic d);
    @(posedge ref_clk);
    upHold = u;
    dnHold = d;
    keys <= {3'h0, u, d};
  endtask : hold
endmodule : dpt_operator
`default_nettype wire

// ### sim/dpt_panel_chk.sv
// concurrent checks on the panel ports, bound to the panel top
`default_nettype none
module dpt_panel_chk (
  // clock and reset
  input wire logic                           ref_clk,
  input wire logic                           nrst,
  // apb
  input wire logic                           psel,
  input wire logic                           penable,
  input wire logic                           pwrite,
  input wire logic                           pready,
  input wire logic                           pslverr,
  // panel, drive and motor
  input wire dpt_pkg::dpt_keys_t             keys,
  input wire dpt_pkg::dpt_disp_t             disp,
  input wire logic                           servoOn,
  input wire logic [dpt_pkg::NUM_FAULT-1:0][15:0] faultCode,
  input wire dpt_pkg::dpt_motor_t            motorCmd
);
  timeunit 1ns;
  timeprecision 1ns;
  import dpt_pkg::*;
  // ****************************************
  // properties
  // ****************************************
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);
  chk_ready_access: assert property (pready == (psel && penable))
    else $error("pready differs from access phase");
  chk_slverr_ready: assert property (pslverr |-> pready)
    else $error("pslverr outside an answered access");
  chk_run_servo: assert property (motorCmd.run |-> servoOn && $past(servoOn))
    else $error("rotation commanded while servo off");
  chk_run_keys: assert property (motorCmd.run |->
    $past(disp.mode) == DSP_JOG && $past(keys.upKey ^ keys.downKey)
    && motorCmd.ccw == $past(keys.upKey))
    else $error("rotation does not follow the arrow keys");
  chk_fault_show: assert property ($rose(disp.mode == DSP_FAULT) &&
    $past(disp.mode) == DSP_NAME |-> disp.value[15:0] == faultCode[$past(disp.value[2:0])])
    else $error("fault view shows a wrong record");
  chk_jog_enter: assert property (disp.mode == DSP_SPEED && keys.setKey
    && !keys.modeKey && !(psel && penable && pwrite) |=> disp.mode == DSP_JOG)
    else $error("set in speed edit does not enter jog");
  chk_jog_exit: assert property (disp.mode == DSP_JOG && keys.modeKey
    && !(psel && penable && pwrite) |=> disp.mode == DSP_NAME && disp.value[3:0] == SEL_JOG)
    else $error("mode in jog does not show the jog name");
  chk_shift_digit: assert property (disp.mode == DSP_SPEED && keys.shiftKey
    && !keys.setKey && !keys.modeKey && !(psel && penable && pwrite)
    |=> disp.blinkDigit != $past(disp.blinkDigit))
    else $error("shift does not move the blinking digit");
  chk_blank_hex: assert property (disp.mode == DSP_HEX && disp.value[19:16] == 4'h0
    |-> disp.blank[4])
    else $error("leading hex zero not blanked");
endmodule : dpt_panel_chk
bind dpt_panel dpt_panel_chk u_dpt_panel_chk (.ref_clk, .nrst, .psel, .penable, .pwrite,
  .pready, .pslverr, .keys, .disp, .servoOn, .faultCode, .motorCmd);
`default_nettype wire

// ### sim/dpt_panel_test.sv
// self-checking bench of the drive panel test functions
`default_nettype none
module dpt_panel_test;
  timeunit 1ns;
  timeprecision 1ns;
  import dpt_pkg::*;
  `define CHK(g, e) begin compares++; if ((g) !== (e)) begin errors++; \
    $display("unexpected at %0t: got %h expected %h", $time, (g), (e)); end end
  localparam dpt_keys_t KSET   = 5'h10;
  localparam dpt_keys_t KMODE  = 5'h08;
  localparam dpt_keys_t KSHIFT = 5'h04;
  localparam dpt_keys_t KUP    = 5'h02;
  localparam dpt_keys_t KDN    = 5'h01;
  logic                            ref_clk      = 1'b0;
  logic                            nrst         = 1'b0;
  logic                            psel         = 1'b0;
  logic                            penable      = 1'b0;
  logic                            pwrite       = 1'b0;
  logic [7:0]                      paddr        = 8'h00;
  logic [31:0]                     pwdata       = 32'h0;
  logic                            servoOn      = 1'b1;
  logic [NUM_DI-1:0]               digitalInput = 9'h000;
  logic [NUM_FUNC-1:0]             funcSig      = 16'h8004;
  logic [31:0]                     prdata;
  logic                            pready;
  logic                            pslverr;
  dpt_keys_t                       keys;
  dpt_disp_t                       disp;
  logic [NUM_FAULT-1:0][15:0]      faultCode;
  dpt_motor_t                      motorCmd;
  logic [NUM_DO-1:0]               digitalOutput;
  logic                            irq;
  logic [8:0]                      inPat [2] = '{9'h1e1, 9'h0a5};
  int                              errors   = 0;
  int                              compares = 0;
  // clock, 40 ns period
  initial forever #20 ref_clk = ~ref_clk;
  dpt_panel u_dpt_panel (.ref_clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .keys, .disp, .servoOn, .faultCode, .motorCmd,
    .digitalInput, .funcSig, .digitalOutput, .irq);
  dpt_operator u_dpt_operator (.ref_clk, .keys, .faultCode);
  // ****************************************
  // access tasks
  // ****************************************
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [31:0] r, output logic e);
    @(posedge ref_clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, a, d, r, e);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    logic [31:0] r;
    logic        e;
    apb(1'b0, a, 32'h0, r, e);
    `CHK(r, x)
  endtask : rd
  task automatic idle(input int n);
    repeat (n) @(negedge ref_clk);
  endtask : idle
  task automatic key(input dpt_keys_t k);
    u_dpt_operator.press(k);
    idle(3);
  endtask : key
  // pins and status register agree on the output map
  task automatic chkOut(input logic [5:0] x);
    idle(3);
    `CHK(digitalOutput, x)
    rd(OFS_OUT_STAT, {26'h0, x});
  endtask : chkOut
  task automatic print_verdict();
    if (errors == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : print_verdict
  // watchdog against a hang
  initial begin
    repeat (5000) @(posedge ref_clk);
    errors++;
    print_verdict();
  end
  // ****************************************
  // tests
  // ****************************************
  initial begin
    logic [31:0] r;
    logic        e;
    repeat (12) @(posedge ref_clk);
    nrst <= 1'b1;
    rd(OFS_JOG_SPEED, 32'h14);
    rd(OFS_FORCE_VAL, 32'h0);
    rd(OFS_OUT_MODE, 32'h190);
    apb(1'b0, 8'h40, 32'h0, r, e);
    `CHK({e, r}, 33'h1_0000_0000)
    for (int i = 0; i < NUM_FAULT; i++) begin
      wr(OFS_PARAM_SEL, 32'(i));
      key(KSET);
      `CHK({disp.mode, disp.value}, {DSP_FAULT, 20'h00e10 + 20'(i)})
    end
    wr(OFS_PARAM_SEL, 32'h5);
    key(KSET);
    `CHK({disp.mode, disp.value}, {DSP_SPEED, 20'h00014})
    key(KUP);
    `CHK(disp.value, 20'h00015)
    key(KSHIFT);
    `CHK({disp.blinkOn, disp.blinkDigit}, 4'h9)
    key(KUP);
    `CHK(disp.value, 20'h0001f)
    key(KDN);
    `CHK(disp.value, 20'h00015)
    key(KSET);
    `CHK(disp.mode, DSP_JOG)
    rd(OFS_JOG_SPEED, 32'h15);
    rd(OFS_IRQ_STAT, 32'h1);
    `CHK(irq, 1'b0)
    wr(OFS_IRQ_MASK, 32'h7);
    idle(2);
    `CHK(irq, 1'b1)
    wr(OFS_IRQ_STAT, 32'h1);
    idle(2);
    `CHK(irq, 1'b0)
    u_dpt_operator.hold(1'b1, 1'b0);
    idle(3);
    `CHK(motorCmd, {1'b1, 1'b1, 16'h0015})
    u_dpt_operator.hold(1'b0, 1'b1);
    idle(3);
    `CHK(motorCmd, {1'b1, 1'b0, 16'h0015})
    u_dpt_operator.hold(1'b1, 1'b1);
    idle(3);
    `CHK(motorCmd.run, 1'b0)
    u_dpt_operator.hold(1'b1, 1'b0);
    idle(3);
    @(posedge ref_clk) servoOn <= 1'b0;
    @(negedge ref_clk);
    `CHK(motorCmd.run, 1'b0)
    idle(3);
    `CHK(motorCmd.run, 1'b0)
    rd(OFS_IRQ_STAT, 32'h2);
    wr(OFS_IRQ_STAT, 32'h2);
    u_dpt_operator.hold(1'b0, 1'b0);
    key(KMODE);
    `CHK({disp.mode, disp.value}, {DSP_NAME, 20'h00005})
    key(KSET);
    `CHK({disp.mode, disp.value}, {DSP_SPEED, 20'h00015})
    chkOut(6'h20);
    wr(OFS_CFG_BASE, 32'h02);
    wr(OFS_CFG_BASE + 8'h04, 32'h10);
    chkOut(6'h23);
    wr(OFS_FORCE_VAL, 32'h2);
    chkOut(6'h23);
    wr(OFS_OUT_MODE, 32'h196);
    chkOut(6'h02);
    wr(OFS_FORCE_VAL, 32'h7);
    chkOut(6'h07);
    @(posedge ref_clk) servoOn <= 1'b1;
    chkOut(6'h23);
    @(posedge ref_clk) servoOn <= 1'b0;
    chkOut(6'h07);
    wr(OFS_PARAM_SEL, 32'h6);
    key(KSET);
    `CHK({disp.mode, disp.value, disp.blank[4]}, {DSP_HEX, 20'h00007, 1'b1})
    wr(OFS_OUT_MODE, 32'h190);
    chkOut(6'h23);
    rd(OFS_IRQ_STAT, 32'h4);
    for (int i = 0; i < 2; i++) begin
      @(posedge ref_clk) digitalInput <= inPat[i];
      rd(OFS_IN_STAT, {23'h0, inPat[i]});
    end
    wr(OFS_PARAM_SEL, 32'h7);
    key(KSET);
    `CHK({disp.mode, disp.value}, {DSP_HEX, 20'h000a5})
    wr(OFS_PARAM_SEL, 32'h9);
    key(KSET);
    `CHK({disp.mode, disp.value}, {DSP_HEX, 20'h00023})
    wr(OFS_PARAM_SEL, 32'ha);
    key(KSET);
    `CHK({disp.mode, disp.value}, {DSP_DEC, 20'h00190})
    wr(OFS_JOG_SPEED, 32'h2000);
    rd(OFS_JOG_SPEED, 32'h1388);
    print_verdict();
  end
endmodule : dpt_panel_test
`default_nettype wire
